// File: rtl/bmo_bank_mode.sv
`timescale 1ns/1ps
module bmo_bank_mode (
  // clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // mode requests
  input wire logic to_read_in,
  input wire logic to_ea_in,
  input wire logic to_aso_in,
  // current mode
  output bmo_pkg::bmo_mode_t mode_out
);
  bmo_pkg::bmo_mode_t mode_reg;
  bmo_pkg::bmo_mode_t mode_next;

  // return to read wins, so a reset command can never be overridden
  always_comb begin
    mode_next = mode_reg;
    if (to_read_in) begin
      mode_next = bmo_pkg::BMO_MODE_READ;
    end else if (to_ea_in) begin
      mode_next = bmo_pkg::BMO_MODE_EA;
    end else if (to_aso_in) begin
      mode_next = bmo_pkg::BMO_MODE_ASO;
    end
  end

  // power-on state is read mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= bmo_pkg::BMO_MODE_READ;
    end else if (ce_in) begin
      mode_reg <= mode_next;
    end
  end

  assign mode_out = mode_reg;
endmodule

// File: rtl/bmo_defs.svh
// Function
// - five spaces: array, id/cfi, otp, lock, config
// - array default, one overlay at most
// - enter command sector bits pick overlaid sector
// - unmapped overlay words read fixed reserved value
// - per-bank mode; one bank busy or overlaid
// - reset paths and array op end return read mode; overlay op end returns overlay mode
// - suspended bank counts as read mode
// - bank in operation reads stable filler data
// - other banks stay readable during operation
// - host waits operation end before overlay enter
// - ignore start or enter while bank occupied
// - other banks, sectors read array during overlay
// - host sends overlay enter to lowest bank
// - only overlaid item programmable; bank goes busy
// - id/cfi and factory otp never programmable
// - full address selects the read word; array reads use only the bank and low offset bits
// - host zeroes offset bits above command bits
// - all reads and writes are sixteen bits
// - host drops byte select bit
// - byte address AAAh becomes word address 555h
`ifndef BMO_DEFS_SVH
`define BMO_DEFS_SVH

// address layout: bank, sector, word offset
`define BMO_BANK_W 4
`define BMO_SECT_W 5
`define BMO_OFS_W 16
`define BMO_ADDR_W 25
`define BMO_DATA_W 16

// command address form
`define BMO_CMD_LSB_W 11
`define BMO_CMD_WORD_ADDR 11'h555
`define BMO_CMD_BYTE_ADDR 12'hAAA

// timing
`define BMO_CLK_PERIOD_NS 100
`define BMO_PROG_TIME_NS 1000
`define BMO_ERASE_TIME_NS 5000
`define BMO_PROG_CYC ((`BMO_PROG_TIME_NS + `BMO_CLK_PERIOD_NS - 1) / `BMO_CLK_PERIOD_NS)
`define BMO_ERASE_CYC ((`BMO_ERASE_TIME_NS + `BMO_CLK_PERIOD_NS - 1) / `BMO_CLK_PERIOD_NS)
`define BMO_TIMER_W 16

// data values
`define BMO_BUSY_DATA 16'h0000
`define BMO_RSVD_DATA 16'hFFFF
`define BMO_ERASED 16'hFFFF
`define BMO_CFG_RESET 16'h0000
`define BMO_ID_TAG 8'h5A

// overlay maps, word offsets within the overlaid sector
`define BMO_IDCFI_WORDS 8
`define BMO_SSR_WORDS 16
`define BMO_SSR_FACT_WORDS 8
`define BMO_LOCK_OFS 16'h0000
`define BMO_CFG_OFS 16'h0000
`define BMO_LOCK_SSR_BIT 0

`endif

// File: rtl/bmo_flash_end.sv
`timescale 1ns/1ps
`include "bmo_defs.svh"
module bmo_flash_end #(
  parameter int WPB = 4,
  parameter int PROG_CYC = `BMO_PROG_CYC,
  parameter int ERASE_CYC = `BMO_ERASE_CYC
) (
  // clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // word bus toward the host
  bmo_if.dev bus,
  // owner record view
  output logic OWNER_VALID_OUT,
  output logic [`BMO_BANK_W-1:0] OWNER_BANK_OUT,
  output logic SUSPENDED_OUT,
  output bmo_pkg::bmo_space_t ASO_SPACE_OUT
);
  localparam int BANKS = 1 << `BMO_BANK_W;
  localparam int WPB_W = $clog2(WPB);
  localparam int WORDS = BANKS * WPB;
  localparam int AW = `BMO_ADDR_W;
  localparam int DW = `BMO_DATA_W;

  // address fields of the current request
  logic [`BMO_BANK_W-1:0] bank;
  logic [`BMO_SECT_W-1:0] sect;
  logic [`BMO_OFS_W-1:0] ofs;
  logic cmd_addr_ok;
  assign bank = bus.addr[AW-1 -: `BMO_BANK_W];
  assign sect = bus.addr[`BMO_OFS_W +: `BMO_SECT_W];
  assign ofs = bus.addr[`BMO_OFS_W-1:0];
  assign cmd_addr_ok = (ofs[`BMO_CMD_LSB_W-1:0] == `BMO_CMD_WORD_ADDR);

  // storage, reduced to WPB words per bank
  logic [DW-1:0] arr_reg [0:WORDS-1];
  logic [DW-1:0] arr_next [0:WORDS-1];
  logic [DW-1:0] ssr_reg [0:`BMO_SSR_WORDS-1];
  logic [DW-1:0] ssr_next [0:`BMO_SSR_WORDS-1];
  logic [DW-1:0] lock_reg, lock_next;
  logic [DW-1:0] cfg_reg, cfg_next;

  // owner record and running job
  logic owner_vld_reg, owner_vld_next;
  logic [`BMO_BANK_W-1:0] owner_bank_reg, owner_bank_next;
  logic susp_reg, susp_next;
  bmo_pkg::bmo_space_t aso_space_reg, aso_space_next;
  logic [`BMO_SECT_W-1:0] aso_sect_reg, aso_sect_next;
  logic [`BMO_TIMER_W-1:0] timer_reg, timer_next;
  logic job_erase_reg, job_erase_next;
  logic job_ovl_reg, job_ovl_next;
  logic [`BMO_OFS_W-1:0] job_ofs_reg, job_ofs_next;
  logic [DW-1:0] job_data_reg, job_data_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // per-bank mode cells
  logic [BANKS-1:0] to_read, to_ea, to_aso;
  bmo_pkg::bmo_mode_t mode [0:BANKS-1];

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      bmo_bank_mode u_mode (
        .clk_in(CORE_CLK_IN),
        .rst_in(RESET_IN),
        .ce_in(CE_IN),
        .to_read_in(to_read[g]),
        .to_ea_in(to_ea[g]),
        .to_aso_in(to_aso[g]),
        .mode_out(mode[g])
      );
    end
  endgenerate

  // derived overlay state
  logic aso_active;
  logic in_ovl_sector;
  logic ovl_wr_ok;
  logic [DW-1:0] rd_word;
  assign aso_active = owner_vld_reg && (mode[owner_bank_reg] == bmo_pkg::BMO_MODE_ASO);
  assign in_ovl_sector = (bank == owner_bank_reg) && (sect == aso_sect_reg);

  // read source selection
  always_comb begin
    rd_word = arr_reg[{bank, ofs[WPB_W-1:0]}];
    if (mode[bank] == bmo_pkg::BMO_MODE_EA) begin
      rd_word = `BMO_BUSY_DATA;
    end else if (aso_active && in_ovl_sector) begin
      rd_word = `BMO_RSVD_DATA;
      unique case (aso_space_reg)
        bmo_pkg::BMO_SP_IDCFI: begin
          if (ofs < `BMO_IDCFI_WORDS) begin
            // tag value is arbitrary
            rd_word = {`BMO_ID_TAG, ofs[7:0]};
          end
        end
        bmo_pkg::BMO_SP_SSR: begin
          if (ofs < `BMO_SSR_WORDS) begin
            rd_word = ssr_reg[ofs[$clog2(`BMO_SSR_WORDS)-1:0]];
          end
        end
        bmo_pkg::BMO_SP_LOCK: begin
          if (ofs == `BMO_LOCK_OFS) begin
            rd_word = lock_reg;
          end
        end
        bmo_pkg::BMO_SP_CFG: begin
          if (ofs == `BMO_CFG_OFS) begin
            rd_word = cfg_reg;
          end
        end
        default: begin
          rd_word = `BMO_RSVD_DATA;
        end
      endcase
    end
  end

  // overlay program gate: customer otp half only while unlocked
  always_comb begin
    ovl_wr_ok = 1'b0;
    unique case (aso_space_reg)
      bmo_pkg::BMO_SP_SSR: ovl_wr_ok = (ofs < `BMO_SSR_WORDS) &&
        (ofs >= `BMO_SSR_FACT_WORDS) && lock_reg[`BMO_LOCK_SSR_BIT];
      bmo_pkg::BMO_SP_LOCK: ovl_wr_ok = (ofs == `BMO_LOCK_OFS);
      bmo_pkg::BMO_SP_CFG: ovl_wr_ok = (ofs == `BMO_CFG_OFS);
      default: ovl_wr_ok = 1'b0;
    endcase
  end

  // command, job and storage next state
  always_comb begin
    arr_next = arr_reg;
    ssr_next = ssr_reg;
    lock_next = lock_reg;
    cfg_next = cfg_reg;
    owner_vld_next = owner_vld_reg;
    owner_bank_next = owner_bank_reg;
    susp_next = susp_reg;
    aso_space_next = aso_space_reg;
    aso_sect_next = aso_sect_reg;
    timer_next = timer_reg;
    job_erase_next = job_erase_reg;
    job_ovl_next = job_ovl_reg;
    job_ofs_next = job_ofs_reg;
    job_data_next = job_data_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    to_read = '0;
    to_ea = '0;
    to_aso = '0;
    // job countdown, frozen while suspended
    if (owner_vld_reg && !susp_reg && (timer_reg != '0)) begin
      timer_next = timer_reg - 1'b1;
      if (timer_reg == 1) begin
        if (job_ovl_reg) begin
          unique case (aso_space_reg)
            bmo_pkg::BMO_SP_SSR: ssr_next[job_ofs_reg[$clog2(`BMO_SSR_WORDS)-1:0]] =
              ssr_reg[job_ofs_reg[$clog2(`BMO_SSR_WORDS)-1:0]] & job_data_reg;
            bmo_pkg::BMO_SP_LOCK: lock_next = lock_reg & job_data_reg;
            bmo_pkg::BMO_SP_CFG: cfg_next = job_data_reg;
            default: cfg_next = cfg_reg;
          endcase
          to_aso[owner_bank_reg] = 1'b1;
        end else begin
          if (job_erase_reg) begin
            for (int w = 0; w < WPB; w++) begin
              arr_next[{owner_bank_reg, w[WPB_W-1:0]}] = `BMO_ERASED;
            end
          end else begin
            arr_next[{owner_bank_reg, job_ofs_reg[WPB_W-1:0]}] =
              arr_reg[{owner_bank_reg, job_ofs_reg[WPB_W-1:0]}] & job_data_reg;
          end
          to_read[owner_bank_reg] = 1'b1;
          owner_vld_next = 1'b0;
        end
      end
    end
    if (bus.req) begin
      unique case (bus.op)
        bmo_pkg::BMO_OP_READ: begin
          rdata_next = rd_word;
          rvalid_next = 1'b1;
        end
        bmo_pkg::BMO_OP_PROGRAM, bmo_pkg::BMO_OP_ERASE: begin
          if (!owner_vld_reg) begin
            owner_vld_next = 1'b1;
            owner_bank_next = bank;
            job_erase_next = (bus.op == bmo_pkg::BMO_OP_ERASE);
            job_ovl_next = 1'b0;
            job_ofs_next = ofs;
            job_data_next = bus.wdata;
            timer_next = (bus.op == bmo_pkg::BMO_OP_ERASE) ?
              `BMO_TIMER_W'(ERASE_CYC) : `BMO_TIMER_W'(PROG_CYC);
            to_ea[bank] = 1'b1;
          end else if (bus.op == bmo_pkg::BMO_OP_PROGRAM && aso_active &&
                       in_ovl_sector && ovl_wr_ok) begin
            job_ovl_next = 1'b1;
            job_erase_next = 1'b0;
            job_ofs_next = ofs;
            job_data_next = bus.wdata;
            timer_next = `BMO_TIMER_W'(PROG_CYC);
            to_ea[owner_bank_reg] = 1'b1;
          end
        end
        bmo_pkg::BMO_OP_ASO_ENTER: begin
          if (!owner_vld_reg && cmd_addr_ok && bank == '0 &&
              bus.space != bmo_pkg::BMO_SP_ARRAY) begin
            owner_vld_next = 1'b1;
            owner_bank_next = bank;
            aso_space_next = bus.space;
            aso_sect_next = sect;
            timer_next = '0;
            to_aso[bank] = 1'b1;
          end
        end
        bmo_pkg::BMO_OP_ASO_EXIT: begin
          if (aso_active && cmd_addr_ok) begin
            owner_vld_next = 1'b0;
            to_read[owner_bank_reg] = 1'b1;
          end
        end
        bmo_pkg::BMO_OP_RESET: begin
          if (cmd_addr_ok) begin
            to_read = '1;
            owner_vld_next = 1'b0;
            susp_next = 1'b0;
            timer_next = '0;
          end
        end
        bmo_pkg::BMO_OP_SUSPEND: begin
          if (owner_vld_reg && !susp_reg && !job_ovl_reg &&
              (timer_reg > 1) && cmd_addr_ok) begin
            susp_next = 1'b1;
            to_read[owner_bank_reg] = 1'b1;
          end
        end
        bmo_pkg::BMO_OP_RESUME: begin
          if (susp_reg && cmd_addr_ok) begin
            susp_next = 1'b0;
            to_ea[owner_bank_reg] = 1'b1;
          end
        end
        default: begin
          rvalid_next = 1'b0;
        end
      endcase
    end
  end

  // registers; storage resets to erased, config to its default
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < WORDS; i++) begin
        arr_reg[i] <= `BMO_ERASED;
      end
      for (int i = 0; i < `BMO_SSR_WORDS; i++) begin
        ssr_reg[i] <= `BMO_ERASED;
      end
      lock_reg <= `BMO_ERASED;
      cfg_reg <= `BMO_CFG_RESET;
      owner_vld_reg <= 1'b0;
      owner_bank_reg <= '0;
      susp_reg <= 1'b0;
      aso_space_reg <= bmo_pkg::BMO_SP_ARRAY;
      aso_sect_reg <= '0;
      timer_reg <= '0;
      job_erase_reg <= 1'b0;
      job_ovl_reg <= 1'b0;
      job_ofs_reg <= '0;
      job_data_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else if (CE_IN) begin
      arr_reg <= arr_next;
      ssr_reg <= ssr_next;
      lock_reg <= lock_next;
      cfg_reg <= cfg_next;
      owner_vld_reg <= owner_vld_next;
      owner_bank_reg <= owner_bank_next;
      susp_reg <= susp_next;
      aso_space_reg <= aso_space_next;
      aso_sect_reg <= aso_sect_next;
      timer_reg <= timer_next;
      job_erase_reg <= job_erase_next;
      job_ovl_reg <= job_ovl_next;
      job_ofs_reg <= job_ofs_next;
      job_data_reg <= job_data_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // outputs; busy covers a suspended job too
  assign bus.rdata = rdata_reg;
  assign bus.rvalid = rvalid_reg;
  assign bus.busy = owner_vld_reg && (timer_reg != '0);
  assign OWNER_VALID_OUT = owner_vld_reg;
  assign OWNER_BANK_OUT = owner_bank_reg;
  assign SUSPENDED_OUT = susp_reg;
  assign ASO_SPACE_OUT = aso_space_reg;
endmodule

// File: rtl/bmo_host_end.sv
`timescale 1ns/1ps
`include "bmo_defs.svh"
module bmo_host_end (
  // clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // user request
  input wire logic USER_REQ_IN,
  input wire bmo_pkg::bmo_op_t USER_OP_IN,
  input wire bmo_pkg::bmo_space_t USER_SPACE_IN,
  input wire logic [`BMO_ADDR_W:0] USER_ADDR_IN,
  input wire logic [`BMO_DATA_W-1:0] USER_WDATA_IN,
  // user answer
  output logic USER_READY_OUT,
  output logic [`BMO_DATA_W-1:0] USER_RDATA_OUT,
  output logic USER_RVALID_OUT,
  // word bus toward the flash
  bmo_if.host bus
);
  localparam int AW = `BMO_ADDR_W;

  bmo_pkg::bmo_hstate_t st_reg, st_next;
  logic req_reg, req_next;
  bmo_pkg::bmo_op_t op_reg, op_next;
  bmo_pkg::bmo_space_t space_reg, space_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [`BMO_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`BMO_DATA_W-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [AW:0] byte_addr;
  logic [AW-1:0] word_addr;

  // byte address shaping per command kind
  always_comb begin
    byte_addr = USER_ADDR_IN;
    unique case (USER_OP_IN)
      bmo_pkg::BMO_OP_READ, bmo_pkg::BMO_OP_PROGRAM: byte_addr = USER_ADDR_IN;
      // erase names a sector only
      bmo_pkg::BMO_OP_ERASE: byte_addr[`BMO_OFS_W:0] = '0;
      default: begin
        byte_addr[`BMO_OFS_W:0] = '0;
        byte_addr[`BMO_CMD_LSB_W:0] = `BMO_CMD_BYTE_ADDR;
      end
    endcase
    if (USER_OP_IN == bmo_pkg::BMO_OP_ASO_ENTER) begin
      byte_addr[AW -: `BMO_BANK_W] = '0;
    end
  end
  assign word_addr = byte_addr[AW:1];

  // request sequencer
  always_comb begin
    st_next = st_reg;
    req_next = 1'b0;
    op_next = op_reg;
    space_next = space_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    unique case (st_reg)
      bmo_pkg::BMO_H_IDLE: begin
        if (USER_REQ_IN) begin
          op_next = USER_OP_IN;
          space_next = USER_SPACE_IN;
          addr_next = word_addr;
          wdata_next = USER_WDATA_IN;
          if (USER_OP_IN == bmo_pkg::BMO_OP_ASO_ENTER && bus.busy) begin
            st_next = bmo_pkg::BMO_H_HOLD;
          end else begin
            req_next = 1'b1;
            if (USER_OP_IN == bmo_pkg::BMO_OP_READ) begin
              st_next = bmo_pkg::BMO_H_READ;
            end
          end
        end
      end
      bmo_pkg::BMO_H_HOLD: begin
        if (!bus.busy) begin
          req_next = 1'b1;
          st_next = bmo_pkg::BMO_H_IDLE;
        end
      end
      bmo_pkg::BMO_H_READ: begin
        if (bus.rvalid) begin
          rdata_next = bus.rdata;
          rvalid_next = 1'b1;
          st_next = bmo_pkg::BMO_H_IDLE;
        end
      end
      default: begin
        st_next = bmo_pkg::BMO_H_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_reg <= bmo_pkg::BMO_H_IDLE;
      req_reg <= 1'b0;
      op_reg <= bmo_pkg::BMO_OP_READ;
      space_reg <= bmo_pkg::BMO_SP_ARRAY;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else if (CE_IN) begin
      st_reg <= st_next;
      req_reg <= req_next;
      op_reg <= op_next;
      space_reg <= space_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // a frozen enable must not repeat the strobe
  assign bus.req = req_reg && CE_IN;
  assign bus.op = op_reg;
  assign bus.space = space_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign USER_READY_OUT = (st_reg == bmo_pkg::BMO_H_IDLE);
  assign USER_RDATA_OUT = rdata_reg;
  assign USER_RVALID_OUT = rvalid_reg;
endmodule

// File: rtl/bmo_if.sv
`timescale 1ns/1ps
`include "bmo_defs.svh"
interface bmo_if;
  logic req;
  bmo_pkg::bmo_op_t op;
  bmo_pkg::bmo_space_t space;
  logic [`BMO_ADDR_W-1:0] addr;
  logic [`BMO_DATA_W-1:0] wdata;
  logic [`BMO_DATA_W-1:0] rdata;
  logic rvalid;
  logic busy;

  modport dev (input req, op, space, addr, wdata, output rdata, rvalid, busy);
  modport host (output req, op, space, addr, wdata, input rdata, rvalid, busy);
endinterface

// File: rtl/bmo_pkg.sv
package bmo_pkg;

  typedef enum logic [1:0] {
    BMO_MODE_READ = 2'b00,
    BMO_MODE_EA = 2'b01,
    BMO_MODE_ASO = 2'b10
  } bmo_mode_t;

  typedef enum logic [2:0] {
    BMO_SP_ARRAY = 3'b000,
    BMO_SP_IDCFI = 3'b001,
    BMO_SP_SSR = 3'b010,
    BMO_SP_LOCK = 3'b011,
    BMO_SP_CFG = 3'b100
  } bmo_space_t;

  typedef enum logic [2:0] {
    BMO_OP_READ = 3'b000,
    BMO_OP_PROGRAM = 3'b001,
    BMO_OP_ERASE = 3'b010,
    BMO_OP_ASO_ENTER = 3'b011,
    BMO_OP_ASO_EXIT = 3'b100,
    BMO_OP_RESET = 3'b101,
    BMO_OP_SUSPEND = 3'b110,
    BMO_OP_RESUME = 3'b111
  } bmo_op_t;

  typedef enum logic [1:0] {
    BMO_H_IDLE = 2'b00,
    BMO_H_HOLD = 2'b01,
    BMO_H_READ = 2'b10
  } bmo_hstate_t;

endpackage

// File: tb/bmo_props.sv
`timescale 1ns/1ps
`include "bmo_defs.svh"
module bmo_props #(
  parameter int PROG_CYC = 10,
  parameter int ERASE_CYC = 50
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  // word bus signals
  input wire logic req,
  input wire bmo_pkg::bmo_op_t op,
  input wire logic [`BMO_ADDR_W-1:0] addr,
  input wire logic [`BMO_DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic busy
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  logic [3:0] req_bank_reg;
  logic [3:0] job_bank_reg;
  logic busy_d_reg;
  int run_cnt_reg;

  // bank of last request, bank owning the job, length of the busy run
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      req_bank_reg <= 4'h0;
      job_bank_reg <= 4'h0;
      busy_d_reg <= 1'b0;
      run_cnt_reg <= 0;
    end else begin
      if (req) req_bank_reg <= addr[24:21];
      if (busy && !busy_d_reg) job_bank_reg <= req_bank_reg;
      busy_d_reg <= busy;
      run_cnt_reg <= busy ? run_cnt_reg + 1 : 0;
    end
  end

  AST_READ_ANSWER: assert property (req && op == bmo_pkg::BMO_OP_READ |=> rvalid)
    else $error("read request got no answer");
  AST_RVALID_CAUSE: assert property (rvalid |-> $past(req) && $past(op) == bmo_pkg::BMO_OP_READ)
    else $error("answer without a read request");
  AST_RDATA_HOLD: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without an answer");
  AST_BUSY_CAUSE: assert property ($rose(busy) |->
      $past(req) && ($past(op) == bmo_pkg::BMO_OP_PROGRAM || $past(op) == bmo_pkg::BMO_OP_ERASE))
    else $error("busy rose without a job start");
  AST_BUSY_MIN: assert property ($rose(busy) |-> busy[*8])
    else $error("job ended too early");
  AST_BUSY_MAX: assert property (run_cnt_reg <= ERASE_CYC)
    else $error("job ran past the longest count");
  AST_JOB_LENGTH: assert property ($fell(busy) |-> run_cnt_reg == PROG_CYC || run_cnt_reg == ERASE_CYC)
    else $error("job length differs from program or erase count");
  AST_BUSY_FILLER: assert property (rvalid && $past(busy) && req_bank_reg == job_bank_reg
      |-> rdata == `BMO_BUSY_DATA)
    else $error("busy bank read returned array data");
endmodule

// File: tb/test_bank_mode_overlay_control.sv
`timescale 1ns/1ps
`include "bmo_defs.svh"
module test_bank_mode_overlay_control;
  // short aliases for ops and spaces
  localparam bmo_pkg::bmo_op_t OP_PRG = bmo_pkg::BMO_OP_PROGRAM;
  localparam bmo_pkg::bmo_op_t OP_ERS = bmo_pkg::BMO_OP_ERASE;
  localparam bmo_pkg::bmo_op_t OP_ENT = bmo_pkg::BMO_OP_ASO_ENTER;
  localparam bmo_pkg::bmo_op_t OP_EXT = bmo_pkg::BMO_OP_ASO_EXIT;
  localparam bmo_pkg::bmo_space_t SP_AR = bmo_pkg::BMO_SP_ARRAY;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic u_req = 1'b0;
  bmo_pkg::bmo_op_t u_op = bmo_pkg::BMO_OP_READ;
  bmo_pkg::bmo_space_t u_sp = SP_AR;
  logic [25:0] u_addr = 26'h0;
  logic [15:0] u_wd = 16'h0;
  logic ready;
  logic rvalid;
  logic [15:0] rdata;
  logic [24:0] bus_addr = 25'h0;
  // shared enable, dropped by the freeze scenario
  logic ce = 1'b1;
  logic owner;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  bmo_if bmo_if_inst ();
  bmo_flash_end #(.PROG_CYC(10), .ERASE_CYC(50)) bmo_flash_end_inst (.CORE_CLK_IN(clk),
    .RESET_IN(rst), .CE_IN(ce), .bus(bmo_if_inst.dev), .OWNER_VALID_OUT(owner), .OWNER_BANK_OUT(),
    .SUSPENDED_OUT(), .ASO_SPACE_OUT());
  bmo_host_end bmo_host_end_inst (.CORE_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce),
    .USER_REQ_IN(u_req), .USER_OP_IN(u_op), .USER_SPACE_IN(u_sp), .USER_ADDR_IN(u_addr),
    .USER_WDATA_IN(u_wd), .USER_READY_OUT(ready), .USER_RDATA_OUT(rdata),
    .USER_RVALID_OUT(rvalid), .bus(bmo_if_inst.host));
  bmo_props #(.PROG_CYC(10), .ERASE_CYC(50)) bmo_props_inst (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .req(bmo_if_inst.req), .op(bmo_if_inst.op), .addr(bmo_if_inst.addr),
    .rdata(bmo_if_inst.rdata), .rvalid(bmo_if_inst.rvalid), .busy(bmo_if_inst.busy));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  // word address as it crossed the wire
  always @(posedge clk) begin
    if (bmo_if_inst.req === 1'b1) bus_addr <= bmo_if_inst.addr;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [24:0] got, input logic [24:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [25:0] ba(input int b, input int s, input int o);
    return {b[3:0], s[4:0], o[15:0], 1'b0};
  endfunction

  // expected wire address: byte bit dropped, command bits forced
  function automatic logic [24:0] wa(input bmo_pkg::bmo_op_t op, input logic [25:0] a);
    logic [24:0] w;
    w = a[25:1];
    if (op != OP_PRG) w[15:0] = 16'h0000;
    if (op > OP_ERS) w[10:0] = 11'h555;
    if (op == OP_ENT) w[24:21] = 4'h0;
    return w;
  endfunction

  // hold request until the host end takes it
  task automatic issue(input bmo_pkg::bmo_op_t op, input bmo_pkg::bmo_space_t sp,
                       input logic [25:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    u_req <= 1'b1;
    u_op <= op;
    u_sp <= sp;
    u_addr <= a;
    u_wd <= d;
    @(negedge clk);
    while (ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    u_req <= 1'b0;
  endtask

  task automatic cmd(input bmo_pkg::bmo_op_t op, input bmo_pkg::bmo_space_t sp,
                     input logic [25:0] a, input logic [15:0] d);
    issue(op, sp, a, d);
    @(posedge clk);
    @(negedge clk);
    chk_addr(bus_addr, wa(op, a));
  endtask

  task automatic rd(input logic [25:0] a, input logic [15:0] exp);
    int n;
    n = 0;
    issue(bmo_pkg::BMO_OP_READ, SP_AR, a, 16'h0000);
    while (rvalid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) n_errors++;
    chk_data(rdata, exp);
    chk_addr(bus_addr, a[25:1]);
  endtask

  task automatic idle;
    int n;
    n = 0;
    while (bmo_if_inst.busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask

  // program and erase with reads of busy and idle banks
  task automatic s_array;
    rd(ba(1, 0, 0), 16'hFFFF);
    cmd(OP_PRG, SP_AR, ba(2, 0, 1), 16'hA55A);
    cmd(OP_PRG, SP_AR, ba(3, 0, 1), 16'h1111);
    rd(ba(2, 0, 1), `BMO_BUSY_DATA);
    rd(ba(3, 0, 1), 16'hFFFF);
    idle();
    rd(ba(2, 0, 1), 16'hA55A);
    rd(ba(2, 0, 0), 16'hFFFF);
    cmd(OP_ERS, SP_AR, ba(2, 0, 7), 16'h0000);
    idle();
    rd(ba(2, 0, 1), 16'hFFFF);
  endtask

  // id overlay over one sector, refusals and command reset
  task automatic s_overlay;
    cmd(OP_PRG, SP_AR, ba(0, 4, 2), 16'h1234);
    issue(OP_ENT, bmo_pkg::BMO_SP_IDCFI, ba(0, 3, 0), 16'h0000);
    rd(ba(0, 3, 2), 16'h5A02);
    rd(ba(0, 3, 9), `BMO_RSVD_DATA);
    rd(ba(0, 4, 2), 16'h1234);
    cmd(OP_PRG, SP_AR, ba(0, 3, 0), 16'h0000);
    chk_data({15'h0, bmo_if_inst.busy}, 16'h0000);
    cmd(OP_ENT, bmo_pkg::BMO_SP_CFG, ba(0, 3, 0), 16'h0000);
    rd(ba(0, 3, 0), 16'h5A00);
    cmd(bmo_pkg::BMO_OP_RESET, SP_AR, ba(0, 0, 0), 16'h0000);
    rd(ba(0, 3, 2), 16'h1234);
  endtask

  // remaining spaces; config and customer otp words programmed, lock word only read
  task automatic s_spaces;
    cmd(OP_ENT, bmo_pkg::BMO_SP_CFG, ba(0, 5, 0), 16'h0000);
    chk_data({15'h0, owner}, 16'h0001);
    rd(ba(0, 5, 0), `BMO_CFG_RESET);
    cmd(OP_PRG, SP_AR, ba(0, 5, 0), 16'h00C3);
    chk_data({15'h0, bmo_if_inst.busy}, 16'h0001);
    idle();
    rd(ba(0, 5, 0), 16'h00C3);
    cmd(OP_EXT, SP_AR, ba(0, 5, 0), 16'h0000);
    rd(ba(0, 5, 0), 16'hFFFF);
    cmd(OP_ENT, bmo_pkg::BMO_SP_SSR, ba(0, 6, 0), 16'h0000);
    cmd(OP_PRG, SP_AR, ba(0, 6, 2), 16'h0000);
    idle();
    rd(ba(0, 6, 2), 16'hFFFF);
    cmd(OP_PRG, SP_AR, ba(0, 6, 9), 16'h0F0F);
    idle();
    rd(ba(0, 6, 9), 16'h0F0F);
    cmd(OP_EXT, SP_AR, ba(0, 6, 0), 16'h0000);
    cmd(OP_ENT, bmo_pkg::BMO_SP_LOCK, ba(0, 7, 0), 16'h0000);
    rd(ba(0, 7, 0), 16'hFFFF);
    cmd(OP_EXT, SP_AR, ba(0, 7, 0), 16'h0000);
  endtask

  // frozen enable: a standing read must not be taken
  task automatic s_freeze;
    @(posedge clk);
    ce <= 1'b0;
    u_req <= 1'b1;
    u_op <= bmo_pkg::BMO_OP_READ;
    repeat (4) @(posedge clk);
    u_req <= 1'b0;
    @(negedge clk);
    chk_data({15'h0, rvalid}, 16'h0000);
    chk_data({15'h0, bmo_if_inst.req}, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(ba(0, 4, 2), 16'h1234);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    s_array();
    s_overlay();
    s_spaces();
    s_freeze();
    close_out();
  end
endmodule
